//--- logic/strx_pkg.sv
package strx_pkg;
  // bus map, byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_TMO = 8'h08;
  localparam logic [7:0] A_ITEM = 8'h0C;
  localparam logic [7:0] A_WSEQ = 8'h10;
  localparam logic [7:0] A_RES = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_IRQ = 8'h1C;
  localparam logic [7:0] A_MASK = 8'h20;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [15:0] BAUD_RST = 16'h2580;
  localparam logic [15:0] TMO_RST = 16'h2710;
  // ctrl bits
  localparam int C_POL = 0;
  localparam int C_TEN = 1;
  localparam int C_SEL = 2;
  // irq bits
  localparam int I_DONE = 0;
  localparam int I_TMO = 1;
  localparam int I_OVR = 2;
  localparam int I_FRM = 3;
  localparam int NIRQ = 4;
  // timing
  localparam int CLK_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLK_HZ = 1000000000 / CLK_NS;
  // character codes
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] HEX_OFS = 8'h37;
  // item kinds
  typedef enum logic [2:0] {
    K_RAW = 3'h0, K_DEC = 3'h1, K_HEX = 3'h2,
    K_BIN = 3'h3, K_SKIP = 3'h4, K_WAIT = 3'h5
  } strx_kind_t;
  // destination widths
  localparam logic [1:0] W_BYTE = 2'h0;
  localparam logic [1:0] W_WORD = 2'h1;
  // item descriptor as written to A_ITEM
  typedef struct packed {
    logic [7:0] rsv2;
    logic [7:0] count;
    logic [1:0] rsv1;
    logic [5:0] limit;
    logic [1:0] rsv0;
    logic [1:0] width;
    logic rsv;
    strx_kind_t kind;
  } strx_item_t;
  // receiver states
  typedef enum logic [4:0] {
    R_IDLE = 5'h01, R_CHK = 5'h02, R_DATA = 5'h04,
    R_STOP = 5'h08, R_GAP = 5'h10
  } strx_rx_t;
endpackage : strx_pkg

//--- logic/strx_top.sv
module strx_top import strx_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RD_DATA,
  input wire logic [1:0] RX_I,
  output logic [1:0] RX_O,
  output logic [1:0] RX_OE,
  output logic IRQ
);
  logic [1:0] s1_q, s2_q;
  logic [2:0] ctrl_q, ctrl_d;
  logic [15:0] baud_q, baud_d, tmo_q, tmo_d;
  logic [31:0] wseq_q, wseq_d, res_q, res_d, rd_q, rd_d;
  logic [NIRQ-1:0] irq_q, irq_d, mask_q, mask_d, ev;
  logic irqo_q, irqo_d;
  logic [1:0] oe_q, oe_d;
  strx_item_t it_q, it_d;
  logic act_q, act_d;
  logic [31:0] acc_q, acc_d;
  logic [5:0] ndig_q, ndig_d;
  logic [7:0] cnt_q, cnt_d;
  strx_rx_t rs_q, rs_d;
  logic [31:0] ph_q, ph_d;
  logic hcnt_q, hcnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic bv_q, bv_d;
  logic [7:0] byte_q, byte_d;
  logic [31:0] msc_q, msc_d;
  logic [15:0] ms_q, ms_d;
  logic line, htick, dv;
  logic [4:0] dval;
  logic [31:0] base, nacc;

  // two-stage synchroniser on both lines
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
    end else begin
      s1_q <= RX_I;
      s2_q <= s1_q;
    end
  end

  // data sense of the selected line
  assign line = ctrl_q[C_POL] ? ~s2_q[ctrl_q[C_SEL]] : s2_q[ctrl_q[C_SEL]];

  // half-bit tick from phase accumulator
  assign htick = (ph_q + {15'h0, baud_q, 1'b0}) >= 32'(CLK_HZ);

  // digit classifier for the active conversion
  always_comb begin
    dv = 1'b0;
    dval = 5'h0;
    base = 32'h0;
    case (it_q.kind)
      K_DEC: begin
        base = 32'hA;
        dv = byte_q >= CH_0 && byte_q <= CH_9;
        dval = 5'(byte_q - CH_0);
      end
      K_HEX: begin
        base = 32'h10;
        if (byte_q >= CH_0 && byte_q <= CH_9) begin
          dv = 1'b1;
          dval = 5'(byte_q - CH_0);
        end else if (byte_q >= CH_A && byte_q <= CH_F) begin
          dv = 1'b1;
          dval = 5'(byte_q - HEX_OFS);
        end
      end
      K_BIN: begin
        base = 32'h2;
        dv = byte_q == CH_0 || byte_q == CH_1;
        dval = 5'(byte_q - CH_0);
      end
      default: begin
      end
    endcase
    nacc = 32'(acc_q * base) + {27'h0, dval};
    if (it_q.kind == K_DEC) begin
      nacc = {16'h0, nacc[15:0]};
    end
  end

  // next state of registers, receiver and item engine
  always_comb begin
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    tmo_d = tmo_q;
    wseq_d = wseq_q;
    mask_d = mask_q;
    it_d = it_q;
    act_d = act_q;
    res_d = res_q;
    acc_d = acc_q;
    ndig_d = ndig_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    rs_d = rs_q;
    ph_d = htick ? ph_q + {15'h0, baud_q, 1'b0} - 32'(CLK_HZ) : ph_q + {15'h0, baud_q, 1'b0};
    hcnt_d = hcnt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    bv_d = 1'b0;
    byte_d = byte_q;
    msc_d = msc_q;
    ms_d = ms_q;
    ev = '0;
    rd_d = 32'h0;
    // receiver
    case (rs_q)
      R_IDLE: begin
        ph_d = 32'h0;
        if (!line) begin
          rs_d = R_CHK;
        end
      end
      R_CHK: begin
        if (htick) begin
          hcnt_d = 1'b0;
          bit_d = 3'h0;
          rs_d = line ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (htick) begin
          hcnt_d = ~hcnt_q;
          if (hcnt_q) begin
            sh_d = {line, sh_q[7:1]};
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              rs_d = R_STOP;
            end
          end
        end
      end
      R_STOP: begin
        if (htick) begin
          hcnt_d = ~hcnt_q;
          if (hcnt_q) begin
            if (line) begin
              bv_d = 1'b1;
              byte_d = sh_q;
              rs_d = R_IDLE;
            end else begin
              ev[I_FRM] = 1'b1;
              rs_d = R_GAP;
            end
          end
        end
      end
      R_GAP: begin
        ph_d = 32'h0;
        if (line) begin
          rs_d = R_IDLE;
        end
      end
      default: rs_d = R_IDLE;
    endcase
    // start wait timer, runs only while idle with an item
    if (act_q && rs_q == R_IDLE && ctrl_q[C_TEN]) begin
      msc_d = msc_q + 32'h1;
      if (msc_q >= 32'(MS_CYCLES - 1)) begin
        msc_d = 32'h0;
        ms_d = ms_q + 16'h1;
      end
      if (ms_q >= tmo_q) begin
        act_d = 1'b0;
        ev[I_TMO] = 1'b1;
      end
    end else begin
      msc_d = 32'h0;
      ms_d = 16'h0;
    end
    // item engine, one byte handled per cycle
    if (bv_q) begin
      if (!act_q) begin
        ev[I_OVR] = 1'b1;
      end else begin
        case (it_q.kind)
          K_RAW: begin
            res_d = {24'h0, byte_q};
            act_d = 1'b0;
            ev[I_DONE] = 1'b1;
          end
          K_SKIP: begin
            cnt_d = cnt_q + 8'h1;
            if (cnt_q + 8'h1 >= it_q.count) begin
              act_d = 1'b0;
              ev[I_DONE] = 1'b1;
            end
          end
          K_WAIT: begin
            if (byte_q == wseq_q[8*cnt_q[1:0] +: 8]) begin
              cnt_d = cnt_q + 8'h1;
              if (cnt_q + 8'h1 >= it_q.count) begin
                it_d.kind = K_RAW;
              end
            end else begin
              cnt_d = (byte_q == wseq_q[7:0]) ? 8'h1 : 8'h0;
            end
          end
          default: begin
            if (dv) begin
              acc_d = nacc;
              ndig_d = ndig_q + 6'h1;
              if (it_q.limit != 6'h0 && ndig_q + 6'h1 >= it_q.limit) begin
                act_d = 1'b0;
                ev[I_DONE] = 1'b1;
              end
            end else if (ndig_q != 6'h0) begin
              act_d = 1'b0;
              ev[I_DONE] = 1'b1;
            end
          end
        endcase
        if (ev[I_DONE] && it_q.kind != K_RAW) begin
          res_d = acc_d;
          if (it_q.width == W_BYTE) begin
            res_d = {24'h0, acc_d[7:0]};
          end else if (it_q.width == W_WORD) begin
            res_d = {16'h0, acc_d[15:0]};
          end
        end
      end
    end
    // register writes
    if (WR_EN) begin
      if (ADDR == A_CTRL) begin
        ctrl_d = WR_DATA[2:0];
      end else if (ADDR == A_BAUD) begin
        baud_d = WR_DATA[15:0];
      end else if (ADDR == A_TMO) begin
        tmo_d = WR_DATA[15:0];
      end else if (ADDR == A_WSEQ) begin
        wseq_d = WR_DATA;
      end else if (ADDR == A_MASK) begin
        mask_d = WR_DATA[NIRQ-1:0];
      end else if (ADDR == A_ITEM) begin
        it_d = strx_item_t'(WR_DATA);
        act_d = 1'b1;
        acc_d = 32'h0;
        ndig_d = 6'h0;
        cnt_d = 8'h0;
        msc_d = 32'h0;
        ms_d = 16'h0;
        oe_d = 2'h0;
        if ((it_d.kind == K_SKIP || it_d.kind == K_WAIT) && it_d.count == 8'h0) begin
          if (it_d.kind == K_SKIP) begin
            act_d = 1'b0;
            ev[I_DONE] = 1'b1;
          end else begin
            it_d.kind = K_RAW;
          end
        end
      end
    end
    // interrupt status, set wins over write-one clear
    irq_d = irq_q;
    if (WR_EN && ADDR == A_IRQ) begin
      irq_d = irq_q & ~WR_DATA[NIRQ-1:0];
    end
    irq_d = irq_d | ev;
    irqo_d = |(irq_d & mask_d);
    // register reads
    if (RD_EN) begin
      if (ADDR == A_CTRL) begin
        rd_d = {29'h0, ctrl_q};
      end else if (ADDR == A_BAUD) begin
        rd_d = {16'h0, baud_q};
      end else if (ADDR == A_TMO) begin
        rd_d = {16'h0, tmo_q};
      end else if (ADDR == A_ITEM) begin
        rd_d = it_q;
      end else if (ADDR == A_WSEQ) begin
        rd_d = wseq_q;
      end else if (ADDR == A_RES) begin
        rd_d = res_q;
      end else if (ADDR == A_STAT) begin
        rd_d = {16'h0, ms_q[7:0], 1'b0, line, rs_q, act_q};
      end else if (ADDR == A_IRQ) begin
        rd_d = {28'h0, irq_q};
      end else if (ADDR == A_MASK) begin
        rd_d = {28'h0, mask_q};
      end
    end
  end

  // state registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      tmo_q <= TMO_RST;
      wseq_q <= 32'h0;
      mask_q <= '0;
      irq_q <= '0;
      irqo_q <= 1'b0;
      it_q <= '0;
      act_q <= 1'b0;
      res_q <= 32'h0;
      rd_q <= 32'h0;
      acc_q <= 32'h0;
      ndig_q <= 6'h0;
      cnt_q <= 8'h0;
      oe_q <= 2'h0;
      rs_q <= R_IDLE;
      ph_q <= 32'h0;
      hcnt_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q <= 8'h0;
      bv_q <= 1'b0;
      byte_q <= 8'h0;
      msc_q <= 32'h0;
      ms_q <= 16'h0;
    end else begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      tmo_q <= tmo_d;
      wseq_q <= wseq_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      irqo_q <= irqo_d;
      it_q <= it_d;
      act_q <= act_d;
      res_q <= res_d;
      rd_q <= rd_d;
      acc_q <= acc_d;
      ndig_q <= ndig_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      rs_q <= rs_d;
      ph_q <= ph_d;
      hcnt_q <= hcnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      bv_q <= bv_d;
      byte_q <= byte_d;
      msc_q <= msc_d;
      ms_q <= ms_d;
    end
  end

  // outputs straight from flops, except RX_O which is tied low
  assign RD_DATA = rd_q;
  assign RX_OE = oe_q;
  assign RX_O = 2'h0;
  assign IRQ = irqo_q;

  // checks
  oe_input_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) act_q |-> RX_OE == 2'h0)
    else $error("line driven during receive");
  tmo_abort_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ev[I_TMO] |=> !act_q && irq_q[I_TMO])
    else $error("timeout did not abort");
  no_tmo_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) !ctrl_q[C_TEN] |-> !ev[I_TMO])
    else $error("timeout while disabled");
  raw_code_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    bv_q && act_q && it_q.kind == K_RAW |=> res_q == {24'h0, $past(byte_q)} && !act_q)
    else $error("raw byte not delivered");
  dec_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    act_q && it_q.kind == K_DEC |-> acc_q[31:16] == 16'h0)
    else $error("decimal accumulator above 16 bits");
  byte_trim_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ev[I_DONE] && act_q && it_q.width == W_BYTE |=> res_q[31:8] == 24'h0)
    else $error("byte result not trimmed");
  lim_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    act_q && it_q.limit != 6'h0 && it_q.kind inside {K_DEC, K_HEX, K_BIN} |-> ndig_q < it_q.limit)
    else $error("digit limit exceeded");
  lead_skip_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    bv_q && act_q && it_q.kind == K_DEC && !dv && ndig_q == 6'h0 |=> act_q)
    else $error("conversion ended without digits");
  ovr_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    bv_q && !act_q |=> irq_q[I_OVR])
    else $error("lost byte not flagged");
  irq_out_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    IRQ == |(irq_q & mask_q))
    else $error("interrupt not raised");
  raw_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) bv_q && act_q && it_q.kind == K_RAW);
  dec_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) ev[I_DONE] && it_q.kind == K_DEC);
  tmo_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) ev[I_TMO]);
  wait_c: cover property (@(posedge REF_CLK) disable iff (!RST_N) it_q.kind == K_WAIT && it_d.kind == K_RAW);
endmodule : strx_top

//--- dv/strx_line_model.sv
module strx_line_model #(
  parameter real BIT_NS = 15259.0
) (
  output logic [1:0] rx_line,
  input wire logic inv,
  input wire logic sel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sense;
  logic lvl;

  // idle mark until a frame starts
  initial begin
    sense = 1'b1;
  end

  // polarity applied, unselected line parked at idle
  assign lvl = sense ^ inv;
  assign rx_line = sel ? {lvl, ~inv} : {~inv, lvl};

  // start, eight data lsb first, one stop
  task automatic send(input logic [7:0] b);
    sense = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      sense = b[i];
      #(BIT_NS);
    end
    sense = 1'b1;
    #(BIT_NS);
  endtask : send
endmodule : strx_line_model

//--- dv/strx_tb_top.sv
module strx_tb_top import strx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, rst_n, wr_en, rd_en, irq, inv, sel;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [1:0] rx_i, rx_o, rx_oe;
  int n_fail, compares;

  // short millisecond keeps timeout runs brief
  strx_top #(.MS_CYCLES(40)) strx_top_i (
    .REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .RX_I(rx_i),
    .RX_O(rx_o), .RX_OE(rx_oe), .IRQ(irq)
  );
  strx_line_model strx_line_model_i (.rx_line(rx_i), .inv(inv), .sel(sel));

  // system clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic finish_test;
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data checked in the following cycle
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk(rd_data, exp);
  endtask : rdchk

  // bounded wait for the interrupt pin
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++)
      @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1)
      finish_test();
  endtask : wait_irq

  // item descriptor word
  function automatic logic [31:0] itm(input strx_kind_t k, input logic [1:0] w, input logic [5:0] lim,
                                      input logic [7:0] cnt);
    return {8'h00, cnt, 2'h0, lim, 2'h0, w, 1'b0, k};
  endfunction : itm

  // issue item, feed text, expect done and result, clear
  task automatic item_run(input logic [31:0] it, input string s, input logic [31:0] res, input bit want);
    wr(A_ITEM, it);
    for (int i = 0; i < s.len(); i++)
      strx_line_model_i.send(s[i]);
    wait_irq(400);
    rdchk(A_IRQ, 32'h1);
    if (want)
      rdchk(A_RES, res);
    wr(A_IRQ, 32'hF);
    repeat (3) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
  endtask : item_run

  // main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    inv = 1'b1;
    sel = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rdchk(A_CTRL, 32'h1);
    rdchk(A_BAUD, 32'h2580);
    @(negedge ref_clk);
    chk(rd_data, 32'h0);
    rdchk(A_TMO, 32'h2710);
    rdchk(8'h24, 32'h0);
    rdchk(A_STAT, 32'h42);
    wr(A_BAUD, 32'hFFFF);
    wr(A_MASK, 32'h3);
    rdchk(A_MASK, 32'h3);
    // timeout off: active item never aborts
    wr(A_TMO, 32'h2);
    wr(A_ITEM, itm(K_RAW, W_BYTE, 6'h00, 8'h00));
    chk({30'h0, rx_oe}, 32'h0);
    chk({30'h0, rx_o}, 32'h0);
    repeat (200) @(posedge ref_clk);
    rdchk(A_IRQ, 32'h0);
    // timeout on: abort after two milliseconds
    wr(A_CTRL, 32'h3);
    repeat (70) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    wait_irq(40);
    rdchk(A_IRQ, 32'h2);
    wr(A_IRQ, 32'hF);
    wr(A_CTRL, 32'h1);
    // inverted line: skip one byte, then a raw code
    item_run(itm(K_SKIP, W_BYTE, 6'h00, 8'h01), "K", 32'h0, 1'b0);
    item_run(itm(K_RAW, W_BYTE, 6'h00, 8'h00), "A", 32'h41, 1'b1);
    // true line sense; switch glitch must fail the half-bit check
    wr(A_CTRL, 32'h0);
    inv <= 1'b0;
    repeat (400) @(posedge ref_clk);
    wr(A_IRQ, 32'hF);
    // leading non-digit dropped, five-digit limit, 70000 wraps at 16 bits
    item_run(itm(K_DEC, W_WORD, 6'h05, 8'h00), "x70000", 32'h1170, 1'b1);
    // hex with three-digit limit, trimmed to a byte
    item_run(itm(K_HEX, W_BYTE, 6'h03, 8'h00), "1FE", 32'hFE, 1'b1);
    // binary, ended by a consumed non-digit
    item_run(itm(K_BIN, W_WORD, 6'h00, 8'h00), "1.", 32'h1, 1'b1);
    // byte with no item is dropped; masked off the pin
    strx_line_model_i.send("G");
    repeat (4) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(A_IRQ, 32'h4);
    wr(A_IRQ, 32'hF);
    // second line, wait for sequence then take next byte
    wr(A_CTRL, 32'h4);
    sel <= 1'b1;
    wr(A_WSEQ, 32'h5958);
    rdchk(A_WSEQ, 32'h5958);
    item_run(itm(K_WAIT, W_BYTE, 6'h00, 8'h02), "XYQ", 32'h51, 1'b1);
    finish_test();
  end
endmodule : strx_tb_top
